// [vgo_defs.vh]
// constants for the video graphics overlay mixer
`ifndef VGO_DEFS_VH
`define VGO_DEFS_VH

// --------
// register byte addresses
// --------
`define VGO_ADDR_CTRL      8'h00
`define VGO_ADDR_HSTART    8'h04
`define VGO_ADDR_HEND      8'h08
`define VGO_ADDR_VSTART    8'h0C
`define VGO_ADDR_VEND      8'h10
`define VGO_ADDR_CKEY_LO   8'h14
`define VGO_ADDR_CKEY_HI   8'h18
`define VGO_ADDR_CHROMA_LO 8'h1C
`define VGO_ADDR_CHROMA_HI 8'h20
`define VGO_ADDR_ALPHA     8'h24
`define VGO_ADDR_FB_BASE   8'h28
`define VGO_ADDR_PAN_OFF   8'h2C
`define VGO_ADDR_FETCH     8'h30
`define VGO_ADDR_ADJUST    8'h34
`define VGO_ADDR_MEAN_CFG  8'h38
`define VGO_ADDR_MEAN      8'h3C
`define VGO_ADDR_DECIM     8'h40

// --------
// control, alpha, adjust and mean config register fields
// --------
`define VGO_CTRL_MODE      3:0
`define VGO_CTRL_DEPTH     5:4
`define VGO_CTRL_DECIM     8
`define VGO_ALPHA_GFX      7:4
`define VGO_ALPHA_VID      15:12
`define VGO_ADJ_GAIN       2:0
`define VGO_ADJ_BRIGHT     15:8
`define VGO_MCFG_PIX       3:0
`define VGO_MCFG_FRM       9:8

// --------
// color depth codes and compare masks
// --------
`define VGO_DEPTH_8        2'h0
`define VGO_DEPTH_16       2'h1
`define VGO_MASK_8         24'h00_00FF
`define VGO_MASK_16        24'hF8_FCF8
`define VGO_MASK_24        24'hFF_FFFF

// --------
// overlay operation modes
// --------
`define VGO_MODE_GFX       4'h0
`define VGO_MODE_AND       4'h1
`define VGO_MODE_CK_NCH    4'h2
`define VGO_MODE_CK        4'h3
`define VGO_MODE_NCK_CH    4'h4
`define VGO_MODE_CH        4'h5
`define VGO_MODE_XOR       4'h6
`define VGO_MODE_OR        4'h7
`define VGO_MODE_NOR       4'h8
`define VGO_MODE_XNOR      4'h9
`define VGO_MODE_NCH_A     4'hA
`define VGO_MODE_CK_OR_NCH 4'hB
`define VGO_MODE_NCH_B     4'hC
`define VGO_MODE_NCK_OR_CH 4'hD
`define VGO_MODE_NAND      4'hE
`define VGO_MODE_BLEND     4'hF

// --------
// misc values
// --------
`define VGO_ZERO32         32'h0000_0000
`define VGO_PIX_MAX        8'hFF
`define VGO_GAIN_UNITY     5'h10

`endif

// [vgo_range_chk.v]
// three-component range comparator used by both keying paths
`timescale 1ns/1ns
module vgo_range_chk #(
    parameter CW = 8
) (
    // compared value and bounds
    input  wire [3*CW-1:0] data,
    input  wire [3*CW-1:0] lo,
    input  wire [3*CW-1:0] hi,
    input  wire [3*CW-1:0] mask,
    // result
    output wire            hit
);
    wire [3*CW-1:0] d_m;
    wire [3*CW-1:0] l_m;
    wire [3*CW-1:0] h_m;
    wire [2:0]      comp_ok;

    // masking drops the bits a narrow color depth does not carry
    assign d_m = data & mask;
    assign l_m = lo & mask;
    assign h_m = hi & mask;

    // every component must sit inside its bounds
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_comp
            assign comp_ok[i] = (d_m[i*CW +: CW] >= l_m[i*CW +: CW]) &&
                                (d_m[i*CW +: CW] <= h_m[i*CW +: CW]);
        end
    endgenerate

    assign hit = &comp_ok;
endmodule // vgo_range_chk

// [vgo_mixer.v]
// overlay mixer: keying, window, panning, contrast, brightness, decimation
//
// How it works
// - mode 0000 graphics, 1111 blended always
// - 0001 both, 0010 color only, 0011 color
// - 0100 chroma only, 0101 any chroma
// - 0110 keys differ, 1001 keys agree
// - 0111 any key, 1000 no key
// - 1010 and 1100 blend without chroma
// - 1011, 1101, 1110 mixed or-combinations
// - window is a four-bound programmable rectangle
// - window counts pixels and lines from syncs
// - fetch address is base plus pan offset
// - color key match switches pixel to blended data
// - mean taken over programmed pixels and frames
// - difference from mean gained 1.0 to 1.4375
// - signed brightness offset added to video
// - decimation merges two host pixels into one
// - blend weights are four alpha msbs
// - color key range test follows depth
// - chroma key range test on video
// - all-zero window disables color key
`timescale 1ns/1ns
`include "vgo_defs.vh"
module vgo_mixer #(
    parameter CNT_W = 12
) (
    // clock and reset
    input  wire        clock,
    input  wire        srst,
    // avalon-mm slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata_ff,
    output reg         avs_waitrequest_ff,
    // pixel stream in
    input  wire [23:0] gfx_pix,
    input  wire [23:0] vid_pix,
    input  wire        pix_de,
    input  wire        pix_hsync,
    input  wire        pix_vsync,
    // pixel stream out
    output reg  [23:0] out_pix_ff,
    output reg         out_de_ff,
    output reg         out_hsync_ff,
    output reg         out_vsync_ff,
    // video memory side
    output reg  [31:0] vid_fetch_addr_ff,
    output reg  [23:0] vid_wr_data_ff,
    output reg         vid_wr_valid_ff
);
    // --------
    // configuration registers
    // --------
    reg [8:0]       ctrl_ff;
    reg [CNT_W-1:0] hstart_ff;
    reg [CNT_W-1:0] hend_ff;
    reg [CNT_W-1:0] vstart_ff;
    reg [CNT_W-1:0] vend_ff;
    reg [23:0]      ckey_lo_ff;
    reg [23:0]      ckey_hi_ff;
    reg [23:0]      chroma_lo_ff;
    reg [23:0]      chroma_hi_ff;
    reg [15:0]      alpha_ff;
    reg [31:0]      fb_base_ff;
    reg [31:0]      pan_off_ff;
    reg [15:0]      adjust_ff;
    reg [9:0]       mean_cfg_ff;
    reg [7:0]       mean_ff;
    reg [23:0]      half_pix_ff;
    reg             half_ff;

    wire wr_ok = avs_write && !avs_waitrequest_ff;
    wire rd_go = avs_read && avs_waitrequest_ff;

    // one wait cycle per access: request seen, then answer for one cycle
    always @(posedge clock) begin
        if (srst) begin
            avs_waitrequest_ff <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest_ff) begin
            avs_waitrequest_ff <= 1'b0;
        end else begin
            avs_waitrequest_ff <= 1'b1;
        end
    end

    // register writes land on the edge that sees waitrequest low
    always @(posedge clock) begin
        if (srst) begin
            ctrl_ff      <= 9'h000;
            hstart_ff    <= {CNT_W{1'b0}};
            hend_ff      <= {CNT_W{1'b0}};
            vstart_ff    <= {CNT_W{1'b0}};
            vend_ff      <= {CNT_W{1'b0}};
            ckey_lo_ff   <= 24'h00_0000;
            ckey_hi_ff   <= 24'h00_0000;
            chroma_lo_ff <= 24'h00_0000;
            chroma_hi_ff <= 24'h00_0000;
            alpha_ff     <= 16'h0000;
            fb_base_ff   <= `VGO_ZERO32;
            pan_off_ff   <= `VGO_ZERO32;
            adjust_ff    <= 16'h0000;
            mean_cfg_ff  <= 10'h000;
        end else if (wr_ok) begin
            if (avs_address == `VGO_ADDR_CTRL) begin
                ctrl_ff <= avs_writedata[8:0];
            end else if (avs_address == `VGO_ADDR_HSTART) begin
                hstart_ff <= avs_writedata[CNT_W-1:0];
            end else if (avs_address == `VGO_ADDR_HEND) begin
                hend_ff <= avs_writedata[CNT_W-1:0];
            end else if (avs_address == `VGO_ADDR_VSTART) begin
                vstart_ff <= avs_writedata[CNT_W-1:0];
            end else if (avs_address == `VGO_ADDR_VEND) begin
                vend_ff <= avs_writedata[CNT_W-1:0];
            end else if (avs_address == `VGO_ADDR_CKEY_LO) begin
                ckey_lo_ff <= avs_writedata[23:0];
            end else if (avs_address == `VGO_ADDR_CKEY_HI) begin
                ckey_hi_ff <= avs_writedata[23:0];
            end else if (avs_address == `VGO_ADDR_CHROMA_LO) begin
                chroma_lo_ff <= avs_writedata[23:0];
            end else if (avs_address == `VGO_ADDR_CHROMA_HI) begin
                chroma_hi_ff <= avs_writedata[23:0];
            end else if (avs_address == `VGO_ADDR_ALPHA) begin
                alpha_ff <= avs_writedata[15:0];
            end else if (avs_address == `VGO_ADDR_FB_BASE) begin
                fb_base_ff <= avs_writedata;
            end else if (avs_address == `VGO_ADDR_PAN_OFF) begin
                pan_off_ff <= avs_writedata;
            end else if (avs_address == `VGO_ADDR_ADJUST) begin
                adjust_ff <= avs_writedata[15:0];
            end else if (avs_address == `VGO_ADDR_MEAN_CFG) begin
                mean_cfg_ff <= avs_writedata[9:0];
            end
        end
    end

    // read mux, captured while waitrequest is still high; unmapped reads zero
    always @(posedge clock) begin
        if (srst) begin
            avs_readdata_ff <= `VGO_ZERO32;
        end else if (rd_go) begin
            if (avs_address == `VGO_ADDR_CTRL) begin
                avs_readdata_ff <= {23'h00_0000, ctrl_ff};
            end else if (avs_address == `VGO_ADDR_HSTART) begin
                avs_readdata_ff <= {{(32-CNT_W){1'b0}}, hstart_ff};
            end else if (avs_address == `VGO_ADDR_HEND) begin
                avs_readdata_ff <= {{(32-CNT_W){1'b0}}, hend_ff};
            end else if (avs_address == `VGO_ADDR_VSTART) begin
                avs_readdata_ff <= {{(32-CNT_W){1'b0}}, vstart_ff};
            end else if (avs_address == `VGO_ADDR_VEND) begin
                avs_readdata_ff <= {{(32-CNT_W){1'b0}}, vend_ff};
            end else if (avs_address == `VGO_ADDR_CKEY_LO) begin
                avs_readdata_ff <= {8'h00, ckey_lo_ff};
            end else if (avs_address == `VGO_ADDR_CKEY_HI) begin
                avs_readdata_ff <= {8'h00, ckey_hi_ff};
            end else if (avs_address == `VGO_ADDR_CHROMA_LO) begin
                avs_readdata_ff <= {8'h00, chroma_lo_ff};
            end else if (avs_address == `VGO_ADDR_CHROMA_HI) begin
                avs_readdata_ff <= {8'h00, chroma_hi_ff};
            end else if (avs_address == `VGO_ADDR_ALPHA) begin
                avs_readdata_ff <= {16'h0000, alpha_ff};
            end else if (avs_address == `VGO_ADDR_FB_BASE) begin
                avs_readdata_ff <= fb_base_ff;
            end else if (avs_address == `VGO_ADDR_PAN_OFF) begin
                avs_readdata_ff <= pan_off_ff;
            end else if (avs_address == `VGO_ADDR_FETCH) begin
                avs_readdata_ff <= vid_fetch_addr_ff;
            end else if (avs_address == `VGO_ADDR_ADJUST) begin
                avs_readdata_ff <= {16'h0000, adjust_ff};
            end else if (avs_address == `VGO_ADDR_MEAN_CFG) begin
                avs_readdata_ff <= {22'h00_0000, mean_cfg_ff};
            end else if (avs_address == `VGO_ADDR_MEAN) begin
                avs_readdata_ff <= {24'h00_0000, mean_ff};
            end else begin
                avs_readdata_ff <= `VGO_ZERO32;
            end
        end
    end

    // --------
    // panning and write decimation
    // --------
    // fetch start follows base and pan continuously
    always @(posedge clock) begin
        if (srst) begin
            vid_fetch_addr_ff <= `VGO_ZERO32;
        end else begin
            vid_fetch_addr_ff <= fb_base_ff + pan_off_ff;
        end
    end

    // halves bandwidth at the cost of horizontal detail
    always @(posedge clock) begin
        if (srst) begin
            half_ff         <= 1'b0;
            half_pix_ff     <= 24'h00_0000;
            vid_wr_data_ff  <= 24'h00_0000;
            vid_wr_valid_ff <= 1'b0;
        end else begin
            vid_wr_valid_ff <= 1'b0;
            if (!ctrl_ff[`VGO_CTRL_DECIM]) begin
                half_ff <= 1'b0;
            end
            if (wr_ok && avs_address == `VGO_ADDR_DECIM) begin
                if (!ctrl_ff[`VGO_CTRL_DECIM]) begin
                    vid_wr_data_ff  <= avs_writedata[23:0];
                    vid_wr_valid_ff <= 1'b1;
                end else if (!half_ff) begin
                    half_pix_ff <= avs_writedata[23:0];
                    half_ff     <= 1'b1;
                end else begin
                    vid_wr_data_ff  <= avg_pix(half_pix_ff, avs_writedata[23:0]);
                    vid_wr_valid_ff <= 1'b1;
                    half_ff         <= 1'b0;
                end
            end
        end
    end

    // --------
    // raster counters and window
    // --------
    reg [CNT_W-1:0] hcnt_ff;
    reg [CNT_W-1:0] vcnt_ff;
    reg             hs_d_ff;
    reg             vs_d_ff;
    wire            hs_rise = pix_hsync && !hs_d_ff;
    wire            vs_rise = pix_vsync && !vs_d_ff;

    // pixels counted from hsync, lines from vsync
    always @(posedge clock) begin
        if (srst) begin
            hcnt_ff <= {CNT_W{1'b0}};
            vcnt_ff <= {CNT_W{1'b0}};
            hs_d_ff <= 1'b0;
            vs_d_ff <= 1'b0;
        end else begin
            hs_d_ff <= pix_hsync;
            vs_d_ff <= pix_vsync;
            if (vs_rise) begin
                vcnt_ff <= {CNT_W{1'b0}};
            end else if (hs_rise) begin
                vcnt_ff <= vcnt_ff + 1'b1;
            end
            if (hs_rise) begin
                hcnt_ff <= {CNT_W{1'b0}};
            end else if (pix_de) begin
                hcnt_ff <= hcnt_ff + 1'b1;
            end
        end
    end

    wire win_zero = ~|{hstart_ff, hend_ff, vstart_ff, vend_ff};
    wire in_win   = (hcnt_ff >= hstart_ff) && (hcnt_ff < hend_ff) &&
                    (vcnt_ff >= vstart_ff) && (vcnt_ff < vend_ff);

    // --------
    // contrast mean over pixels and frames
    // --------
    reg [15:0] mpix_ff;
    reg [2:0]  mfrm_ff;
    reg [27:0] msum_ff;
    wire [15:0] pix_lim = 16'h0001 << mean_cfg_ff[`VGO_MCFG_PIX];
    wire [2:0]  frm_lim = (3'h1 << mean_cfg_ff[`VGO_MCFG_FRM]) - 3'h1;
    wire [9:0]  luma    = {2'h0, vid_pix[23:16]} + {1'h0, vid_pix[15:8], 1'h0} + {2'h0, vid_pix[7:0]};
    wire [4:0]  mshift  = {1'h0, mean_cfg_ff[`VGO_MCFG_PIX]} + {3'h0, mean_cfg_ff[`VGO_MCFG_FRM]};
    wire [27:0] msum_sh = msum_ff >> mshift;

    // first pix_lim active pixels of each frame are summed
    always @(posedge clock) begin
        if (srst) begin
            mpix_ff <= 16'h0000;
            mfrm_ff <= 3'h0;
            msum_ff <= 28'h000_0000;
            mean_ff <= 8'h00;
        end else if (vs_rise) begin
            mpix_ff <= 16'h0000;
            if (mfrm_ff >= frm_lim) begin
                mean_ff <= msum_sh[9:2];
                msum_ff <= 28'h000_0000;
                mfrm_ff <= 3'h0;
            end else begin
                mfrm_ff <= mfrm_ff + 3'h1;
            end
        end else if (pix_de && mpix_ff < pix_lim) begin
            mpix_ff <= mpix_ff + 16'h0001;
            msum_ff <= msum_ff + {18'h0_0000, luma};
        end
    end

    // --------
    // pixel arithmetic
    // --------
    // mean + (v - mean) * (16 + gain) / 16 + brightness, clamped
    function [7:0] adj_comp;
        input [7:0] v;
        input [7:0] m;
        input [2:0] g;
        input [7:0] b;
        reg signed [9:0]  d;
        reg signed [15:0] p;
        reg signed [15:0] r;
        begin
            d = $signed({2'h0, v}) - $signed({2'h0, m});
            p = d * $signed({1'h0, `VGO_GAIN_UNITY + {2'h0, g}});
            r = (p >>> 4) + $signed({8'h00, m}) + $signed({{8{b[7]}}, b});
            if (r < 0) begin
                adj_comp = 8'h00;
            end else if (r > $signed({8'h00, `VGO_PIX_MAX})) begin
                adj_comp = `VGO_PIX_MAX;
            end else begin
                adj_comp = r[7:0];
            end
        end
    endfunction

    // weighted sum with four-bit weights, clamped
    function [7:0] blend_comp;
        input [7:0] g;
        input [7:0] v;
        input [3:0] ga;
        input [3:0] va;
        reg [12:0] s;
        begin
            s = g * ga + v * va;
            blend_comp = (s[12:4] > {1'h0, `VGO_PIX_MAX}) ? `VGO_PIX_MAX : s[11:4];
        end
    endfunction

    function [23:0] avg_pix;
        input [23:0] a;
        input [23:0] b;
        reg [8:0] s2;
        reg [8:0] s1;
        reg [8:0] s0;
        begin
            s2 = a[23:16] + b[23:16];
            s1 = a[15:8] + b[15:8];
            s0 = a[7:0] + b[7:0];
            avg_pix = {s2[8:1], s1[8:1], s0[8:1]};
        end
    endfunction

    // overlay mode truth table: 1 selects blended data
    function sel_blend;
        input [3:0] md;
        input       ck;
        input       ch;
        begin
            case (md)
                `VGO_MODE_GFX:       sel_blend = 1'b0;
                `VGO_MODE_AND:       sel_blend = ck & ch;
                `VGO_MODE_CK_NCH:    sel_blend = ck & !ch;
                `VGO_MODE_CK:        sel_blend = ck;
                `VGO_MODE_NCK_CH:    sel_blend = !ck & ch;
                `VGO_MODE_CH:        sel_blend = ch;
                `VGO_MODE_XOR:       sel_blend = ck ^ ch;
                `VGO_MODE_OR:        sel_blend = ck | ch;
                `VGO_MODE_NOR:       sel_blend = !ck & !ch;
                `VGO_MODE_XNOR:      sel_blend = ck ~^ ch;
                `VGO_MODE_NCH_A:     sel_blend = !ch;
                `VGO_MODE_CK_OR_NCH: sel_blend = ck | !ch;
                `VGO_MODE_NCH_B:     sel_blend = !ch;
                `VGO_MODE_NCK_OR_CH: sel_blend = !ck | ch;
                `VGO_MODE_NAND:      sel_blend = !ck | !ch;
                default:             sel_blend = 1'b1;
            endcase
        end
    endfunction

    // --------
    // keying and output stage
    // --------
    wire [7:0]  bright = adjust_ff[`VGO_ADJ_BRIGHT];
    wire [2:0]  gain   = adjust_ff[`VGO_ADJ_GAIN];
    wire [23:0] vid_adj = {adj_comp(vid_pix[23:16], mean_ff, gain, bright),
                           adj_comp(vid_pix[15:8], mean_ff, gain, bright),
                           adj_comp(vid_pix[7:0], mean_ff, gain, bright)};
    wire [3:0]  ga = alpha_ff[`VGO_ALPHA_GFX];
    wire [3:0]  va = alpha_ff[`VGO_ALPHA_VID];
    wire [23:0] blended = {blend_comp(gfx_pix[23:16], vid_adj[23:16], ga, va),
                           blend_comp(gfx_pix[15:8], vid_adj[15:8], ga, va),
                           blend_comp(gfx_pix[7:0], vid_adj[7:0], ga, va)};
    wire [1:0]  depth = ctrl_ff[`VGO_CTRL_DEPTH];
    wire [23:0] ck_mask = (depth == `VGO_DEPTH_8)  ? `VGO_MASK_8 :
                          (depth == `VGO_DEPTH_16) ? `VGO_MASK_16 : `VGO_MASK_24;
    wire        ck_raw;
    wire        ch_raw;

    vgo_range_chk #(.CW(8)) u_color_key (
        .data (gfx_pix),
        .lo   (ckey_lo_ff),
        .hi   (ckey_hi_ff),
        .mask (ck_mask),
        .hit  (ck_raw)
    );

    vgo_range_chk #(.CW(8)) u_chroma_key (
        .data (vid_adj),
        .lo   (chroma_lo_ff),
        .hi   (chroma_hi_ff),
        .mask (`VGO_MASK_24),
        .hit  (ch_raw)
    );

    // color key only counts inside an enabled window during active scan
    wire ck_hit = ck_raw && pix_de && in_win && !win_zero;
    wire ch_hit = ch_raw && pix_de && in_win;

    // one pipeline stage; syncs delayed to stay aligned with pixels
    always @(posedge clock) begin
        if (srst) begin
            out_pix_ff   <= 24'h00_0000;
            out_de_ff    <= 1'b0;
            out_hsync_ff <= 1'b0;
            out_vsync_ff <= 1'b0;
        end else begin
            out_de_ff    <= pix_de;
            out_hsync_ff <= pix_hsync;
            out_vsync_ff <= pix_vsync;
            if (sel_blend(ctrl_ff[`VGO_CTRL_MODE], ck_hit, ch_hit)) begin
                out_pix_ff <= blended;
            end else begin
                out_pix_ff <= gfx_pix;
            end
        end
    end
endmodule // vgo_mixer

// [vgo_mixer_props.sv]
// port checker for the overlay mixer, bound into it
`timescale 1ns/1ns
module vgo_mixer_chk (
    // clock, reset and register bus
    input wire        clock,
    input wire        srst,
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata_ff,
    input wire        avs_waitrequest_ff,
    // pixel and memory side
    input wire [23:0] gfx_pix,
    input wire [23:0] out_pix_ff,
    input wire [23:0] vid_wr_data_ff,
    input wire        vid_wr_valid_ff
);
    // --------
    // ctrl shadow, loaded on the same accepting edge as the real one
    // --------
    reg  [8:0] ctl_ff;
    wire       acc  = avs_write && !avs_waitrequest_ff;
    wire       wr40 = acc && avs_address == 8'h40;
    always @(posedge clock)
        ctl_ff <= srst ? 9'h000 : (acc && avs_address == 8'h00) ? avs_writedata[8:0] : ctl_ff;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    a_rst_values: assert property (disable iff (1'b0) srst |=> avs_waitrequest_ff && !vid_wr_valid_ff
        && out_pix_ff == 24'h00_0000) else $error("outputs not cleared by reset");
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest_ff |=> !avs_waitrequest_ff)
        else $error("bus request not answered next cycle");
    a_wait_pulse: assert property (!avs_waitrequest_ff |=> avs_waitrequest_ff)
        else $error("waitrequest low longer than one cycle");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest_ff && avs_address == 8'h44
        |-> avs_readdata_ff == 32'h0000_0000) else $error("unmapped read not zero");
    a_gfx_mode: assert property (ctl_ff[3:0] == 4'h0 |=> out_pix_ff == $past(gfx_pix))
        else $error("mode zero did not pass graphics");
    a_plain_write: assert property (wr40 && !ctl_ff[8] |=> vid_wr_valid_ff
        && vid_wr_data_ff == $past(avs_writedata[23:0])) else $error("plain video write lost");
    a_valid_cause: assert property (vid_wr_valid_ff |-> $past(wr40))
        else $error("video write without host write");
    a_valid_pulse: assert property (vid_wr_valid_ff |=> !vid_wr_valid_ff)
        else $error("video write valid too long");
endmodule // vgo_mixer_chk
bind vgo_mixer vgo_mixer_chk i_vgo_mixer_chk (.clock(clock), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(avs_readdata_ff),
    .avs_waitrequest_ff(avs_waitrequest_ff), .gfx_pix(gfx_pix), .out_pix_ff(out_pix_ff),
    .vid_wr_data_ff(vid_wr_data_ff), .vid_wr_valid_ff(vid_wr_valid_ff));

// [vgo_disp_src.sv]
// display timing source feeding the mixer
`timescale 1ns/1ns
module vgo_disp_src (
    // clock and reset
    input  wire clock,
    input  wire srst,
    // display timing
    output reg  pix_de    = 1'b0,
    output reg  pix_hsync = 1'b0,
    output reg  pix_vsync = 1'b0
);
    reg [7:0] pos_ff = 8'h00;
    // 32-pixel lines, 8-line frames; enable drops at line end so keying sees blanking
    always @(posedge clock) begin
        pos_ff    <= srst ? 8'h00 : pos_ff + 8'h01;
        pix_de    <= pos_ff[4:0] < 5'h1C;
        pix_hsync <= pos_ff[4:0] == 5'h1F;
        pix_vsync <= pos_ff == 8'hFF;
    end
endmodule // vgo_disp_src

// [testbench.sv]
// self-checking bench for the overlay mixer
`timescale 1ns/1ns
module testbench;
    // --------
    // signals and model state
    // --------
    logic        clock, srst, avs_read, avs_write, win;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, seed, q, base;
    logic [23:0] gfx_pix, vid_pix, wr_last;
    logic [3:0]  mode;
    wire         pix_de, pix_hsync, pix_vsync, wait_ff, wr_valid;
    wire  [31:0] rdata, fetch;
    wire  [23:0] out_pix, wr_data;
    wire  [2:0]  out_sync;
    integer      fail_count, n_compared, bright, wr_n, mn, gn;
    localparam logic [63:0] TBL = 64'hF7B5_D591_E6A2_C480; // blend select by {mode, ck, ch}
    vgo_disp_src i_vgo_disp_src (.clock(clock), .srst(srst), .pix_de(pix_de), .pix_hsync(pix_hsync),
        .pix_vsync(pix_vsync));
    vgo_mixer i_vgo_mixer (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata_ff(rdata),
        .avs_waitrequest_ff(wait_ff), .gfx_pix(gfx_pix), .vid_pix(vid_pix), .pix_de(pix_de),
        .pix_hsync(pix_hsync), .pix_vsync(pix_vsync), .out_pix_ff(out_pix), .out_de_ff(out_sync[2]),
        .out_hsync_ff(out_sync[1]), .out_vsync_ff(out_sync[0]), .vid_fetch_addr_ff(fetch),
        .vid_wr_data_ff(wr_data), .vid_wr_valid_ff(wr_valid));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected pixel: contrast and brightness with clamp, half/half blend, gated keys
    function automatic logic [23:0] exp_pix(input logic de, input logic [23:0] g, input logic [23:0] v);
        logic [23:0] a, b;
        logic        ck, ch;
        int          t;
        for (int i = 0; i < 24; i += 8) begin
            t = mn + (((int'(v[i+:8]) - mn) * (16 + gn)) >>> 4) + bright;
            a[i+:8] = t < 0 ? 8'h00 : t > 255 ? 8'hFF : t[7:0];
            b[i+:8] = ({1'b0, g[i+:8]} + a[i+:8]) >> 1;
        end
        ck = de && win && !(g[23] | g[15] | g[7]);
        ch = de && win && !(a[23] | a[15] | a[7]);
        return TBL[{mode, ck, ch}] ? b : g;
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clock); while (wait_ff !== 1'b0);
        q = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        check(q, e);
    endtask
    // output lags the sampled inputs by one edge
    task pix_run(input int n, input logic hold = 1'b0);
        logic [26:0] e;
        repeat (n) begin
            @(posedge clock);
            e = {exp_pix(pix_de, gfx_pix, vid_pix), pix_de, pix_hsync, pix_vsync};
            seed = lfsr(seed);
            gfx_pix <= seed[23:0];
            seed = lfsr(seed);
            if (!hold) vid_pix <= seed[31:8];
            #1 check({out_pix, out_sync}, e);
        end
    endtask
    task wrap_up;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) if (srst) wr_n <= 0;
    else if (wr_valid === 1'b1) begin
        wr_n <= wr_n + 1;
        wr_last <= wr_data;
    end
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        #200_000;
        fail_count++;
        wrap_up;
    end
    initial begin
        {srst, avs_read, avs_write, avs_address, avs_writedata, gfx_pix, vid_pix} = {1'b1, 90'h0};
        {seed, mode, win, bright, mn, gn, fail_count, n_compared} = {32'h0000_0061, 4'h0, 1'b1, 160'h0};
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        rd(8'h00, 32'h0000_0000);
        base = lfsr(seed);
        seed = lfsr(base);
        wr(8'h28, base);
        wr(8'h2C, seed);
        wr(8'h30, 32'h0000_0000);
        rd(8'h30, base + seed);
        check(fetch, base + seed);
        rd(8'h44, 32'h0000_0000);
        wr(8'h18, 32'h007F_7F7F);
        wr(8'h20, 32'h007F_7F7F);
        wr(8'h24, 32'h0000_8080);
        for (int w = 1; w >= 0; w--) begin
            win = w[0];
            wr(8'h08, {20'h0_0000, {12{win}}});
            wr(8'h10, {20'h0_0000, {12{win}}});
            for (int m = 0; m < 16; m++) begin
                mode = m[3:0];
                wr(8'h00, {24'h00_0000, 4'h2, mode});
                pix_run(40);
            end
        end
        bright = 127;
        wr(8'h34, 32'h0000_7F00);
        pix_run(40);
        bright = -128;
        wr(8'h34, 32'h0000_8000);
        pix_run(40);
        // flat video for two frames: luma 256, so the mean settles at 64
        bright = 0;
        vid_pix <= 24'h80_4000;
        repeat (600) @(posedge clock);
        rd(8'h3C, 32'h0000_0040);
        mn = 64;
        gn = 7;
        wr(8'h34, 32'h0000_0007);
        pix_run(40, 1'b1);
        wr(8'h00, 32'h0000_0020);
        wr(8'h40, 32'h0012_3456);
        repeat (2) @(posedge clock);
        check(wr_n, 1);
        wr(8'h00, 32'h0000_0120);
        wr(8'h40, 32'h0010_2030);
        wr(8'h40, 32'h0031_4051);
        repeat (2) @(posedge clock);
        check(wr_n, 2);
        check(wr_last, 24'h20_3040);
        wrap_up;
    end
endmodule // testbench
